// ### include/clbst_pkg.sv
// ****************************************************************
// Constants
// ****************************************************************
`default_nettype none
package clbst_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_NODE_A_BTR = 8'h00;
   localparam logic [7:0] ADDR_NODE_B_BTR = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_OBJ_BASE = 8'h40;
   // Field positions
   localparam int LOOPBACK_SELECT_BIT = 15;
   localparam int OBJ_VALID_LSB = 0;
   localparam int OBJ_TRANSMIT_REQUEST_FLAG_BIT = 2;
   localparam int OBJ_SINGLE_TRY_BIT = 3;
   localparam int OBJ_SENT_BIT = 4;
   // Object valid field codes
   localparam logic [1:0] OBJ_INVALID = 2'h1;
   localparam logic [1:0] OBJ_VALID = 2'h2;
   // Reset values
   localparam logic [15:0] BTR_RESET = 16'h0000;
   localparam logic [1:0] OBJ_VALID_RESET = 2'h1;
   // Bus answer
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [1:0] {
      CLBST_IDLE = 2'b00,
      CLBST_ANSWER = 2'b01
   } clbst_bus_t;
endpackage
`default_nettype wire

// ### hw/clbst_top.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module clbst_top
   import clbst_pkg::*;
#(
   parameter int NUM_OBJ = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Protocol engine side
   input wire logic eng_a_tx,
   input wire logic eng_b_tx,
   output logic eng_a_rx,
   output logic eng_b_rx,
   input wire logic [$clog2(NUM_OBJ)-1:0] eng_obj_sel,
   input wire logic eng_a_start,
   input wire logic eng_b_start,
   input wire logic eng_done,
   output logic [NUM_OBJ-1:0] obj_tx_ready,
   // Transceiver pins
   input wire logic pin_a_rx,
   input wire logic pin_b_rx,
   output logic pin_a_tx,
   output logic pin_b_tx
);
   localparam int IW = $clog2(NUM_OBJ);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [15:0] node_a_bit_timing_reg;
   logic [15:0] node_b_bit_timing_reg;
   logic [1:0] object_valid_field [NUM_OBJ];
   logic [NUM_OBJ-1:0] transmit_request_flag;
   logic [NUM_OBJ-1:0] single_try_enable;
   logic [NUM_OBJ-1:0] sent_once;
   clbst_bus_t bus_reg;
   logic loopback_reg;
   logic frame_start;
   logic wr_hit, rd_hit;
   logic obj_hit;
   logic [IW-1:0] obj_idx;

   assign frame_start = eng_a_start | eng_b_start;
   // Writes land at the edge where waitrequest is seen low
   assign wr_hit = avs_write && bus_reg == CLBST_ANSWER;
   assign rd_hit = avs_read && bus_reg == CLBST_IDLE;
   assign obj_hit = avs_address >= ADDR_OBJ_BASE &&
      avs_address < ADDR_OBJ_BASE + 8'(4 * NUM_OBJ);
   assign obj_idx = IW'((avs_address - ADDR_OBJ_BASE) >> 2);

   // ****************************************************************
   // Bus handshake: one wait cycle, answer on the second
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_reg <= CLBST_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (bus_reg)
            CLBST_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_reg <= CLBST_ANSWER;
                  avs_waitrequest <= 1'b0;
               end
            end
            CLBST_ANSWER: begin
               bus_reg <= CLBST_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_reg <= CLBST_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= UNMAPPED_READ;
      end else if (rd_hit) begin
         if (avs_address == ADDR_NODE_A_BTR) begin
            avs_readdata <= {16'h0000, node_a_bit_timing_reg};
         end else if (avs_address == ADDR_NODE_B_BTR) begin
            avs_readdata <= {16'h0000, node_b_bit_timing_reg};
         end else if (avs_address == ADDR_STATUS) begin
            avs_readdata <= {31'h0, loopback_reg};
         end else if (obj_hit) begin
            avs_readdata <= {27'h0, sent_once[obj_idx], single_try_enable[obj_idx],
               transmit_request_flag[obj_idx], object_valid_field[obj_idx]};
         end else begin
            avs_readdata <= UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         node_a_bit_timing_reg <= BTR_RESET;
         node_b_bit_timing_reg <= BTR_RESET;
      end else if (wr_hit) begin
         if (avs_address == ADDR_NODE_A_BTR) begin
            node_a_bit_timing_reg <= avs_writedata[15:0];
         end
         if (avs_address == ADDR_NODE_B_BTR) begin
            node_b_bit_timing_reg <= avs_writedata[15:0];
         end
      end
   end

   // ****************************************************************
   // Message objects
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            object_valid_field[i] <= OBJ_VALID_RESET;
         end
         transmit_request_flag <= '0;
         single_try_enable <= '0;
         sent_once <= '0;
      end else begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            if (wr_hit && obj_hit && obj_idx == IW'(i)) begin
               if (avs_writedata[OBJ_VALID_LSB +: 2] == OBJ_VALID ||
                  avs_writedata[OBJ_VALID_LSB +: 2] == OBJ_INVALID) begin
                  object_valid_field[i] <= avs_writedata[OBJ_VALID_LSB +: 2];
               end
               transmit_request_flag[i] <= avs_writedata[OBJ_TRANSMIT_REQUEST_FLAG_BIT];
               single_try_enable[i] <= avs_writedata[OBJ_SINGLE_TRY_BIT];
               if (avs_writedata[OBJ_TRANSMIT_REQUEST_FLAG_BIT]) begin
                  sent_once[i] <= 1'b0;
               end
            end
            if (frame_start && eng_obj_sel == IW'(i) && obj_tx_ready[i]) begin
               // Single-try objects clear at frame start, hardware wins
               if (single_try_enable[i]) begin
                  transmit_request_flag[i] <= 1'b0;
                  sent_once[i] <= 1'b1;
               end
            end else if (eng_done && eng_obj_sel == IW'(i) &&
               !(wr_hit && obj_hit && obj_idx == IW'(i))) begin
               // Software set wins over a same-cycle done clear
               transmit_request_flag[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         obj_tx_ready <= '0;
      end else begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            obj_tx_ready[i] <= transmit_request_flag[i] &&
               object_valid_field[i] == OBJ_VALID &&
               !(frame_start && eng_obj_sel == IW'(i) && single_try_enable[i]);
         end
      end
   end

   // ****************************************************************
   // Loop-back path
   // ****************************************************************
   // Both select bits needed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loopback_reg <= 1'b0;
      end else begin
         loopback_reg <= node_a_bit_timing_reg[LOOPBACK_SELECT_BIT] &
            node_b_bit_timing_reg[LOOPBACK_SELECT_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_a_tx <= 1'b1;
         pin_b_tx <= 1'b1;
         eng_a_rx <= 1'b1;
         eng_b_rx <= 1'b1;
      end else if (loopback_reg) begin
         pin_a_tx <= 1'b1;
         pin_b_tx <= 1'b1;
         eng_a_rx <= eng_a_tx & eng_b_tx;
         eng_b_rx <= eng_a_tx & eng_b_tx;
      end else begin
         pin_a_tx <= eng_a_tx;
         pin_b_tx <= eng_b_tx;
         eng_a_rx <= pin_a_rx;
         eng_b_rx <= pin_b_rx;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_loop_on;
      node_a_bit_timing_reg[LOOPBACK_SELECT_BIT] && node_b_bit_timing_reg[LOOPBACK_SELECT_BIT];
   endsequence
   sequence s_loop_off;
      !node_a_bit_timing_reg[LOOPBACK_SELECT_BIT] || !node_b_bit_timing_reg[LOOPBACK_SELECT_BIT];
   endsequence

   a_pins_recessive: assert property (
      @(posedge clk) disable iff (!nrst) s_loop_on ##1 s_loop_on |=> pin_a_tx && pin_b_tx)
      else $error("transmit pin not recessive in loop-back");
   a_loop_join: assert property (
      @(posedge clk) disable iff (!nrst) loopback_reg |=>
      eng_a_rx == ($past(eng_a_tx) & $past(eng_b_tx)) && eng_b_rx == eng_a_rx)
      else $error("loop-back receive not joined transmit");
   a_rx_isolated: assert property (
      @(posedge clk) disable iff (!nrst) loopback_reg && (!pin_a_rx || !pin_b_rx) && eng_a_tx
      && eng_b_tx |=> eng_a_rx && eng_b_rx)
      else $error("external receive leaked in loop-back");
   a_loop_select: assert property (
      @(posedge clk) disable iff (!nrst) s_loop_off |=> !loopback_reg)
      else $error("loop-back on without both select bits");
   a_single_clear: assert property (
      @(posedge clk) disable iff (!nrst)
      frame_start && obj_tx_ready[eng_obj_sel] && single_try_enable[eng_obj_sel] |=>
      !transmit_request_flag[$past(eng_obj_sel)])
      else $error("single-try request not cleared");
   a_no_retry: assert property (
      @(posedge clk) disable iff (!nrst)
      frame_start && obj_tx_ready[eng_obj_sel] && single_try_enable[eng_obj_sel] |=>
      ##1 !obj_tx_ready[$past(eng_obj_sel, 2)]
      || $past(wr_hit))
      else $error("single-try object offered again");
   a_valid_only: assert property (
      @(posedge clk) disable iff (!nrst)
      object_valid_field[eng_obj_sel] != OBJ_VALID |=> !obj_tx_ready[$past(eng_obj_sel)])
      else $error("invalid object ready to send");
   a_valid_codes: assert property (
      @(posedge clk) disable iff (!nrst)
      object_valid_field[eng_obj_sel] == OBJ_VALID || object_valid_field[eng_obj_sel] == OBJ_INVALID)
      else $error("illegal valid code stored");
   a_dominant_wins: assert property (
      @(posedge clk) disable iff (!nrst) loopback_reg && (!eng_a_tx || !eng_b_tx) |=>
      !eng_a_rx && !eng_b_rx)
      else $error("dominant level lost in loop-back");
endmodule
`default_nettype wire

// ### tb/clbst_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Transceiver model: bus level seen back on the receive pin
// ****************************************************************
module clbst_xcvr_model (
   // Node side
   input wire logic tx,
   output logic rx,
   // Other bus traffic, high drives dominant
   input wire logic bus_dom
);
   // Recessive is 1, any dominant driver pulls the bus low
   assign rx = tx & ~bus_dom;
endmodule
`default_nettype wire

// ### tb/clbst_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clbst_top_tb;
   import clbst_pkg::*;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, obj_tx_ready, q;
   logic eng_a_tx, eng_b_tx, eng_a_rx, eng_b_rx, eng_a_start, eng_b_start, eng_done;
   logic [4:0] eng_obj_sel;
   logic pin_a_rx, pin_b_rx, pin_a_tx, pin_b_tx, dom_a, dom_b;
   int n_fail, total_checks;
   clbst_top #(.NUM_OBJ(32)) i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eng_a_tx(eng_a_tx),
      .eng_b_tx(eng_b_tx), .eng_a_rx(eng_a_rx), .eng_b_rx(eng_b_rx), .eng_obj_sel(eng_obj_sel),
      .eng_a_start(eng_a_start), .eng_b_start(eng_b_start), .eng_done(eng_done),
      .obj_tx_ready(obj_tx_ready), .pin_a_rx(pin_a_rx), .pin_b_rx(pin_b_rx),
      .pin_a_tx(pin_a_tx), .pin_b_tx(pin_b_tx));
   clbst_xcvr_model i_xa (.tx(pin_a_tx), .rx(pin_a_rx), .bus_dom(dom_a));
   clbst_xcvr_model i_xb (.tx(pin_b_tx), .rx(pin_b_rx), .bus_dom(dom_b));
   // ****************************************************************
   // Common tasks
   // ****************************************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 100) begin
         n_fail++;
      end
      @(posedge clk);
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, q, exp);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      chk("pin_a_tx", {31'h0, pin_a_tx}, 32'h1);
      rd("btr_a", ADDR_NODE_A_BTR, 32'h0000_0000);
      rd("obj0", ADDR_OBJ_BASE, 32'h0000_0001);
      rd("unmapped", 8'h3c, UNMAPPED_READ);
   endtask
   task automatic t_loop;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, ADDR_NODE_A_BTR, {16'h0, i[1], 15'h0});
         bus(1'b1, ADDR_NODE_B_BTR, {16'h0, i[0], 15'h0});
         rd("status", ADDR_STATUS, {31'h0, i[1] & i[0]});
      end
      eng_a_tx <= 1'b0;
      dom_a <= 1'b1;
      dom_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pins_tx", {30'h0, pin_a_tx, pin_b_tx}, 32'h3);
      chk("eng_rx", {30'h0, eng_a_rx, eng_b_rx}, 32'h0);
      eng_a_tx <= 1'b1;
      repeat (3) @(posedge clk);
      chk("eng_rx_free", {30'h0, eng_a_rx, eng_b_rx}, 32'h3);
      bus(1'b1, ADDR_NODE_A_BTR, 32'h0000_0000);
      eng_b_tx <= 1'b0;
      dom_a <= 1'b0;
      dom_b <= 1'b0;
      repeat (3) @(posedge clk);
      chk("eng_rx_off", {30'h0, eng_a_rx, eng_b_rx}, 32'h2);
      chk("pins_off", {30'h0, pin_a_tx, pin_b_tx}, 32'h2);
      eng_b_tx <= 1'b1;
   endtask
   task automatic t_single;
      bus(1'b1, ADDR_OBJ_BASE + 8'h04, 32'h0000_000e);
      repeat (2) @(posedge clk);
      chk("ready1", {31'h0, obj_tx_ready[1]}, 32'h1);
      for (int k = 0; k < 2; k++) begin
         eng_obj_sel <= 5'h01;
         eng_a_start <= 1'b1;
         @(posedge clk);
         eng_a_start <= 1'b0;
         repeat (2) @(posedge clk);
         chk("ready1_started", {31'h0, obj_tx_ready[1]}, 32'h0);
      end
      rd("obj1", ADDR_OBJ_BASE + 8'h04, 32'h0000_001a);
   endtask
   task automatic t_normal;
      bus(1'b1, ADDR_OBJ_BASE + 8'h0c, 32'h0000_0006);
      repeat (2) @(posedge clk);
      eng_obj_sel <= 5'h03;
      eng_b_start <= 1'b1;
      @(posedge clk);
      eng_b_start <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ready3_retry", {31'h0, obj_tx_ready[3]}, 32'h1);
      eng_done <= 1'b1;
      @(posedge clk);
      eng_done <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ready3_done", {31'h0, obj_tx_ready[3]}, 32'h0);
      rd("obj3", ADDR_OBJ_BASE + 8'h0c, 32'h0000_0002);
   endtask
   task automatic t_valid;
      bus(1'b1, ADDR_OBJ_BASE + 8'h08, 32'h0000_0005);
      repeat (2) @(posedge clk);
      chk("ready2_invalid", {31'h0, obj_tx_ready[2]}, 32'h0);
      bus(1'b1, ADDR_OBJ_BASE + 8'h08, 32'h0000_0007);
      rd("obj2", ADDR_OBJ_BASE + 8'h08, 32'h0000_0005);
      bus(1'b1, ADDR_OBJ_BASE + 8'h08, 32'h0000_0006);
      repeat (2) @(posedge clk);
      chk("ready2_valid", {31'h0, obj_tx_ready[2]}, 32'h1);
   endtask
   // ****************************************************************
   // Clock, reset, sequence, watchdog
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
   initial begin
      {nrst, avs_read, avs_write, eng_a_start, eng_b_start, eng_done, dom_a, dom_b} = '0;
      {avs_address, avs_writedata, eng_obj_sel} = '0;
      eng_a_tx = 1'b1;
      eng_b_tx = 1'b1;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_loop();
      t_single();
      t_normal();
      t_valid();
      finish_test();
   end
endmodule
`default_nettype wire
